// >>> charger_pin_cfg.svh
`ifndef CHARGER_PIN_CFG_SVH
`define CHARGER_PIN_CFG_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define REG_CTRL        4'h0
`define REG_HOLD        4'h1
`define REG_WAKE1       4'h2
`define REG_WAKE2       4'h3
`define REG_INPUT_LIMIT_PROGRAM        4'h4
`define REG_TERM        4'h5
`define REG_STATUS      4'h6
`define REG_IRQ_STAT    4'h7
`define REG_IRQ_MASK    4'h8
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTRL_IND_EN     0
`define CTRL_MIRROR     1
`define CTRL_SHIP       2
`define OVR_VALID       15
`define IRQ_FAULT       0
`define IRQ_TS          1
`define IRQ_WAKE1       2
`define IRQ_WAKE2       3
`define IRQ_RESET       4
// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define CTRL_RST        16'h0001
`define HOLD_RST        16'h1388
`define WAKE1_RST       16'h01F4
`define WAKE2_RST       16'h0BB8
`define INPUT_LIMIT_PROGRAM_DEFAULT    8'h08
`define TERM_DEFAULT    5'h0A
`define TERM_MIN        5'h05
`define TERM_MAX        5'h14
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_MHZ         100
`define FAULT_PULSE_US  128
`define RELEASE_MS      400
`define MS_PER_S_US     1000
`endif

// >>> charger_pin_pkg.sv
package charger_pin_pkg;
    typedef enum logic [1:0] {
        BTN_IDLE    = 2'b00,
        BTN_PRESSED = 2'b01,
        BTN_RESET   = 2'b10,
        BTN_WAIT    = 2'b11
    } btn_state_t;
endpackage

// >>> charger_pin_control_status.sv
// Operation
// - chip_disable low: battery alone high-Z, valid supply charges unless in ship mode.
// - chip_disable high: battery alone active, supply never charges.
// - rail output follows its enable.
// - status_irq low while charging, else released.
// - one 128 us low pulse per fault.
// - indicator enable bit gates charge indication.
// - power_good_n low only while supply is in range.
// - mirror select: power_good_n follows manual_reset_n.
// - reset low once manual_reset_n held low beyond hold time.
// - reset released after the 400 ms delay.
// - short press interrupts at wake_time_1 and wake_time_2.
// - manual_reset_n press ends ship mode.
// - input limit: default if pin grounded, serial override wins.
// - termination 5 to 20 percent, also pre-charge.
// - four thermistor thresholds; fault reported while charging.
`include "charger_pin_cfg.svh"
`timescale 1ns/1ns
module charger_pin_control_status #(
    parameter int MS_CYCLES    = `CLK_MHZ * `MS_PER_S_US,
    parameter int PULSE_CYCLES = `CLK_MHZ * `FAULT_PULSE_US
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    input  wire logic        chipDisable,
    input  wire logic        switchedRailEnable,
    input  wire logic        manualResetN,
    input  wire logic        batteryPresent,
    input  wire logic        inputAboveSleep,
    input  wire logic        inputBelowOvp,
    input  wire logic        chargeDone,
    input  wire logic        faultIn,
    input  wire logic        tsBelowCold,
    input  wire logic        tsBelowCool,
    input  wire logic        tsAboveWarm,
    input  wire logic        tsAboveHot,
    input  wire logic        inputLimitPinGrounded,
    input  wire logic [7:0]  inputLimitPinCode,
    input  wire logic        termPinGrounded,
    input  wire logic [4:0]  termPinPct,
    output logic             switchedRailOutput,
    output logic             statusIrqOe,
    output logic             powerGoodOe,
    output logic             resetOe,
    output logic             chargeEnable,
    output logic             hiZMode,
    output logic             activeBatteryMode,
    output logic             shipMode,
    output logic      [7:0]  inputLimitCode,
    output logic      [4:0]  termCurrentPct,
    output logic      [4:0]  preChargePct,
    output logic             irq
);
    localparam int MSW = $clog2(MS_CYCLES);
    localparam int PW  = $clog2(PULSE_CYCLES + 1);
    localparam logic [MSW-1:0] MS_LAST   = MSW'(MS_CYCLES - 1);
    localparam logic [PW-1:0]  PULSE_LEN = PW'(PULSE_CYCLES);
    localparam logic [15:0]    REL_LAST  = 16'(`RELEASE_MS - 1);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    generate
        if (MS_CYCLES < 2 || PULSE_CYCLES < 1) begin : g_bad
            $error("counts too small");
        end
    endgenerate

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                 sync1;
        logic [2:0]                 sync2;
        logic                       faultLast;
        logic [MSW-1:0]             msCnt;
        logic                       msTick;
        charger_pin_pkg::btn_state_t btn;
        logic [15:0]                pressMs;
        logic [15:0]                relMs;
        logic                       wake1Done;
        logic                       wake2Done;
        logic [PW-1:0]              pulseCnt;
        logic [15:0]                ctrl;
        logic [15:0]                hold;
        logic [15:0]                wake1;
        logic [15:0]                wake2;
        logic [8:0]                 ilimOvr;
        logic [5:0]                 termOvr;
        logic [4:0]                 irqStat;
        logic [4:0]                 irqMask;
        logic [15:0]                rdata;
        logic                       railOn;
        logic                       statOe;
        logic                       pgOe;
        logic                       rstOe;
        logic                       chgEn;
        logic                       hiZ;
        logic                       actBatt;
        logic                       ship;
        logic [7:0]                 ilimCode;
        logic [4:0]                 termPct;
        logic                       irqOut;
    } state_t;

    state_t cur_ff;
    state_t nxt_st;

    function automatic logic [4:0] clampTerm(input logic [4:0] pct);
        if (pct < `TERM_MIN) begin
            return `TERM_MIN;
        end else if (pct > `TERM_MAX) begin
            return `TERM_MAX;
        end
        return pct;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic       mrN;
        logic       cdS;
        logic       lsS;
        logic       supplyGood;
        logic       charging;
        logic       tsFault;
        logic       faultNow;
        logic       faultRise;
        logic       pressed;
        logic [4:0] events;
        logic [4:0] clr;
        logic [15:0] rd;
        mrN        = 1'b1;
        cdS        = 1'b0;
        lsS        = 1'b0;
        supplyGood = 1'b0;
        charging   = 1'b0;
        tsFault    = 1'b0;
        faultNow   = 1'b0;
        faultRise  = 1'b0;
        pressed    = 1'b0;
        events     = 5'h00;
        clr        = 5'h00;
        rd         = 16'h0000;
        nxt_st     = cur_ff;

        // metastable first stage only feeds the second
        nxt_st.sync1 = {manualResetN, chipDisable, switchedRailEnable};
        nxt_st.sync2 = cur_ff.sync1;
        mrN = cur_ff.sync2[2];
        cdS = cur_ff.sync2[1];
        lsS = cur_ff.sync2[0];
        pressed = !mrN;

        // 1 ms enable
        nxt_st.msTick = 1'b0;
        if (cur_ff.msCnt == MS_LAST) begin
            nxt_st.msCnt  = '0;
            nxt_st.msTick = 1'b1;
        end else begin
            nxt_st.msCnt = cur_ff.msCnt + 1'b1;
        end

        // ------------------------------------------------------------
        // power path mode
        // ------------------------------------------------------------
        supplyGood = inputAboveSleep && inputBelowOvp;
        nxt_st.chgEn   = supplyGood && !cdS && !cur_ff.ship;
        nxt_st.hiZ     = !supplyGood && batteryPresent && !cdS;
        nxt_st.actBatt = !supplyGood && batteryPresent && cdS;
        nxt_st.railOn  = lsS;

        charging = cur_ff.chgEn && !chargeDone;
        // cold/hot flag a fault while charging; chgEn is not cleared
        tsFault  = charging && (tsBelowCold || tsAboveHot);

        // ------------------------------------------------------------
        // fault pulse on status_irq
        // ------------------------------------------------------------
        faultNow = faultIn || tsFault;
        nxt_st.faultLast = faultNow;
        faultRise = faultNow && !cur_ff.faultLast;
        // a new fault restarts a running pulse
        if (faultRise) begin
            nxt_st.pulseCnt = PULSE_LEN;
        end else if (cur_ff.pulseCnt != '0) begin
            nxt_st.pulseCnt = cur_ff.pulseCnt - 1'b1;
        end
        nxt_st.statOe = (nxt_st.pulseCnt != '0)
                     || (cur_ff.ctrl[`CTRL_IND_EN] && charging);

        // ------------------------------------------------------------
        // power good / button mirror
        // ------------------------------------------------------------
        if (cur_ff.ctrl[`CTRL_MIRROR]) begin
            nxt_st.pgOe = pressed;
        end else begin
            nxt_st.pgOe = supplyGood;
        end

        // ------------------------------------------------------------
        // manual reset button
        // ------------------------------------------------------------
        case (cur_ff.btn)
            charger_pin_pkg::BTN_IDLE: begin
                nxt_st.pressMs   = 16'h0000;
                nxt_st.wake1Done = 1'b0;
                nxt_st.wake2Done = 1'b0;
                if (pressed) begin
                    nxt_st.btn  = charger_pin_pkg::BTN_PRESSED;
                    nxt_st.ship = 1'b0;
                end
            end
            charger_pin_pkg::BTN_PRESSED: begin
                if (!pressed) begin
                    nxt_st.btn = charger_pin_pkg::BTN_IDLE;
                end else if (cur_ff.pressMs > cur_ff.hold) begin
                    nxt_st.btn   = charger_pin_pkg::BTN_RESET;
                    nxt_st.relMs = 16'h0000;
                    events[`IRQ_RESET] = 1'b1;
                end else begin
                    if (cur_ff.msTick && cur_ff.pressMs != 16'hFFFF) begin
                        nxt_st.pressMs = cur_ff.pressMs + 16'h0001;
                    end
                    if (!cur_ff.wake1Done && cur_ff.pressMs >= cur_ff.wake1) begin
                        nxt_st.wake1Done   = 1'b1;
                        events[`IRQ_WAKE1] = 1'b1;
                    end
                    if (!cur_ff.wake2Done && cur_ff.pressMs >= cur_ff.wake2) begin
                        nxt_st.wake2Done   = 1'b1;
                        events[`IRQ_WAKE2] = 1'b1;
                    end
                end
            end
            charger_pin_pkg::BTN_RESET: begin
                // runs out even if released
                if (cur_ff.msTick) begin
                    if (cur_ff.relMs == REL_LAST) begin
                        nxt_st.btn = charger_pin_pkg::BTN_WAIT;
                    end else begin
                        nxt_st.relMs = cur_ff.relMs + 16'h0001;
                    end
                end
            end
            charger_pin_pkg::BTN_WAIT: begin
                // no retrigger while held
                if (!pressed) begin
                    nxt_st.btn = charger_pin_pkg::BTN_IDLE;
                end
            end
            default: begin
                nxt_st.btn = charger_pin_pkg::BTN_IDLE;
            end
        endcase
        nxt_st.rstOe = (nxt_st.btn == charger_pin_pkg::BTN_RESET);

        events[`IRQ_FAULT] = faultIn && !cur_ff.faultLast;
        events[`IRQ_TS]    = tsFault;

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (regWr) begin
            if (regAddr == `REG_CTRL) begin
                nxt_st.ctrl = {14'h0000, regWdata[`CTRL_MIRROR],
                               regWdata[`CTRL_IND_EN]};
                if (regWdata[`CTRL_SHIP]) begin
                    nxt_st.ship = 1'b1;
                end
            end else if (regAddr == `REG_HOLD) begin
                nxt_st.hold = regWdata;
            end else if (regAddr == `REG_WAKE1) begin
                nxt_st.wake1 = regWdata;
            end else if (regAddr == `REG_WAKE2) begin
                nxt_st.wake2 = regWdata;
            end else if (regAddr == `REG_INPUT_LIMIT_PROGRAM) begin
                nxt_st.ilimOvr = {regWdata[`OVR_VALID], regWdata[7:0]};
            end else if (regAddr == `REG_TERM) begin
                nxt_st.termOvr = {regWdata[`OVR_VALID], clampTerm(regWdata[4:0])};
            end else if (regAddr == `REG_IRQ_STAT) begin
                clr = regWdata[4:0];
            end else if (regAddr == `REG_IRQ_MASK) begin
                nxt_st.irqMask = regWdata[4:0];
            end
        end
        // set beats clear
        nxt_st.irqStat = (cur_ff.irqStat & ~clr) | events;
        nxt_st.irqOut  = |(nxt_st.irqStat & nxt_st.irqMask);

        // ------------------------------------------------------------
        // limit and termination selection
        // ------------------------------------------------------------
        if (cur_ff.ilimOvr[8]) begin
            nxt_st.ilimCode = cur_ff.ilimOvr[7:0];
        end else if (inputLimitPinGrounded) begin
            nxt_st.ilimCode = `INPUT_LIMIT_PROGRAM_DEFAULT;
        end else begin
            nxt_st.ilimCode = inputLimitPinCode;
        end
        if (cur_ff.termOvr[5]) begin
            nxt_st.termPct = cur_ff.termOvr[4:0];
        end else if (termPinGrounded) begin
            nxt_st.termPct = `TERM_DEFAULT;
        end else begin
            nxt_st.termPct = clampTerm(termPinPct);
        end

        // ------------------------------------------------------------
        // register reads
        // ------------------------------------------------------------
        if (regAddr == `REG_CTRL) begin
            rd = {13'h0000, cur_ff.ship, cur_ff.ctrl[1:0]};
        end else if (regAddr == `REG_HOLD) begin
            rd = cur_ff.hold;
        end else if (regAddr == `REG_WAKE1) begin
            rd = cur_ff.wake1;
        end else if (regAddr == `REG_WAKE2) begin
            rd = cur_ff.wake2;
        end else if (regAddr == `REG_INPUT_LIMIT_PROGRAM) begin
            rd = {cur_ff.ilimOvr[8], 7'h00, cur_ff.ilimOvr[7:0]};
        end else if (regAddr == `REG_TERM) begin
            rd = {cur_ff.termOvr[5], 10'h000, cur_ff.termOvr[4:0]};
        end else if (regAddr == `REG_STATUS) begin
            rd = {4'h0, tsBelowCold, tsBelowCool, tsAboveWarm, tsAboveHot,
                  cur_ff.rstOe, pressed, charging, supplyGood,
                  cur_ff.actBatt, cur_ff.hiZ, cur_ff.chgEn, cur_ff.railOn};
        end else if (regAddr == `REG_IRQ_STAT) begin
            rd = {11'h000, cur_ff.irqStat};
        end else if (regAddr == `REG_IRQ_MASK) begin
            rd = {11'h000, cur_ff.irqMask};
        end
        nxt_st.rdata = regRd ? rd : 16'h0000;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_ff           <= '0;
            cur_ff.sync1     <= 3'h4;
            cur_ff.sync2     <= 3'h4;
            cur_ff.ctrl      <= `CTRL_RST;
            cur_ff.hold      <= `HOLD_RST;
            cur_ff.wake1     <= `WAKE1_RST;
            cur_ff.wake2     <= `WAKE2_RST;
            cur_ff.ilimCode  <= `INPUT_LIMIT_PROGRAM_DEFAULT;
            cur_ff.termPct   <= `TERM_DEFAULT;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign regRdata           = cur_ff.rdata;
    assign switchedRailOutput = cur_ff.railOn;
    assign statusIrqOe        = cur_ff.statOe;
    assign powerGoodOe        = cur_ff.pgOe;
    assign resetOe            = cur_ff.rstOe;
    assign chargeEnable       = cur_ff.chgEn;
    assign hiZMode            = cur_ff.hiZ;
    assign activeBatteryMode  = cur_ff.actBatt;
    assign shipMode           = cur_ff.ship;
    assign inputLimitCode     = cur_ff.ilimCode;
    assign termCurrentPct     = cur_ff.termPct;
    // same setting for pre-charge
    assign preChargePct       = cur_ff.termPct;
    assign irq                = cur_ff.irqOut;
endmodule

// >>> host_pins_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host pull-ups
// ----------------------------------------
module host_pins_model (
    input  wire logic statusIrqOe,
    input  wire logic powerGoodOe,
    input  wire logic resetOe,
    output wire logic statusIrqN,
    output wire logic powerGoodN,
    output wire logic resetN
);
    // released line shows its pull-up
    assign statusIrqN = !statusIrqOe;
    assign powerGoodN = !powerGoodOe;
    assign resetN     = !resetOe;
endmodule

// >>> charger_pin_control_status_asserts.sv
`timescale 1ns/1ns
module charger_pin_control_status_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic chipDisable,
    input wire logic switchedRailEnable,
    input wire logic manualResetN,
    input wire logic batteryPresent,
    input wire logic inputAboveSleep,
    input wire logic inputBelowOvp,
    input wire logic faultIn,
    input wire logic tsBelowCold,
    input wire logic tsAboveHot,
    input wire logic switchedRailOutput,
    input wire logic statusIrqOe,
    input wire logic powerGoodOe,
    input wire logic resetOe,
    input wire logic chargeEnable,
    input wire logic hiZMode
);
    // two ticks of slack below, one above, for the divider phase
    localparam int REL_MIN = 3980;
    localparam int REL_MAX = 4010;
    logic [2:0]  upCnt_ff;
    logic [12:0] relRun_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            upCnt_ff  <= 3'h0;
            relRun_ff <= 13'h0000;
        end else begin
            upCnt_ff  <= (upCnt_ff == 3'h7) ? upCnt_ff : upCnt_ff + 3'h1;
            relRun_ff <= resetOe ? relRun_ff + 13'h0001 : 13'h0000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_rail_follow:
    assert property (upCnt_ff == 3'h7 |-> switchedRailOutput == $past(switchedRailEnable, 3))
        else $error("rail lag");
    chk_cd_inhibit:
    assert property (upCnt_ff == 3'h7 && $past(chipDisable, 3) |-> !chargeEnable)
        else $error("charge with cd");
    chk_charge_cause:
    assert property (chargeEnable |-> $past(inputAboveSleep) && $past(inputBelowOvp))
        else $error("charge no supply");
    chk_hiz_cause:
    assert property (hiZMode |-> $past(batteryPresent) && !($past(inputAboveSleep) && $past(inputBelowOvp)))
        else $error("hiz with supply");
    chk_pgood_on:
    assert property (upCnt_ff != 3'h0 && $past(inputAboveSleep) && $past(inputBelowOvp) |-> powerGoodOe)
        else $error("pg not low");
    chk_fault_pulse:
    assert property (upCnt_ff == 3'h7 && $rose(faultIn) |-> ##1 statusIrqOe [*8])
        else $error("pulse short");
    chk_irq_cause:
    assert property ($rose(statusIrqOe) |-> chargeEnable || $past(chargeEnable) || $past(faultIn)
                     || $past(tsBelowCold) || $past(tsAboveHot))
        else $error("irq no cause");
    chk_reset_press:
    assert property ($rose(resetOe) |-> !$past(manualResetN) && !$past(manualResetN, 10))
        else $error("reset no press");
    chk_release_min:
    assert property (upCnt_ff != 3'h0 && $fell(resetOe) |-> $past(relRun_ff) >= REL_MIN)
        else $error("early release");
    chk_release_max:
    assert property (relRun_ff <= REL_MAX)
        else $error("late release");
endmodule
bind charger_pin_control_status charger_pin_control_status_asserts chk_u (
    .clk(clk), .rst(rst), .chipDisable(chipDisable), .switchedRailEnable(switchedRailEnable),
    .manualResetN(manualResetN), .batteryPresent(batteryPresent),
    .inputAboveSleep(inputAboveSleep), .inputBelowOvp(inputBelowOvp), .faultIn(faultIn),
    .tsBelowCold(tsBelowCold), .tsAboveHot(tsAboveHot), .switchedRailOutput(switchedRailOutput),
    .statusIrqOe(statusIrqOe), .powerGoodOe(powerGoodOe), .resetOe(resetOe),
    .chargeEnable(chargeEnable), .hiZMode(hiZMode));

// >>> charger_pin_control_status_tb.sv
`timescale 1ns/1ns
`include "charger_pin_cfg.svh"
module charger_pin_control_status_tb;
    logic        clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000, regRdata;
    logic        cd = 1'b0, railEn = 1'b0, mr = 1'b1, bat = 1'b1, above = 1'b0, ovp = 1'b1;
    logic        done = 1'b0, fault = 1'b0, cold = 1'b0, cool = 1'b0, warm = 1'b0, hot = 1'b0;
    logic        ilimGnd = 1'b1, termGnd = 1'b1;
    logic [7:0]  ilimPin = 8'h00, ilimCode;
    logic [4:0]  termPin = 5'h00, termPct, prePct;
    logic        rail, irqOe, pgOe, rstOe, chgEn, hiZ, actBat, ship, irq, irqN, pgN, rstN;
    int          failCount = 0, nCompared = 0, n;
    always #5 clk = ~clk;
    charger_pin_control_status #(.MS_CYCLES(10), .PULSE_CYCLES(8)) dut_u (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .chipDisable(cd), .switchedRailEnable(railEn),
        .manualResetN(mr), .batteryPresent(bat), .inputAboveSleep(above), .inputBelowOvp(ovp),
        .chargeDone(done), .faultIn(fault), .tsBelowCold(cold), .tsBelowCool(cool),
        .tsAboveWarm(warm), .tsAboveHot(hot), .inputLimitPinGrounded(ilimGnd),
        .inputLimitPinCode(ilimPin), .termPinGrounded(termGnd), .termPinPct(termPin),
        .switchedRailOutput(rail), .statusIrqOe(irqOe), .powerGoodOe(pgOe), .resetOe(rstOe),
        .chargeEnable(chgEn), .hiZMode(hiZ), .activeBatteryMode(actBat), .shipMode(ship),
        .inputLimitCode(ilimCode), .termCurrentPct(termPct), .preChargePct(prePct), .irq(irq));
    host_pins_model host_u (.statusIrqOe(irqOe), .powerGoodOe(pgOe), .resetOe(rstOe),
        .statusIrqN(irqN), .powerGoodN(pgN), .resetN(rstN));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        nCompared++;
        if (g !== e) begin
            failCount++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk("rdata", e, regRdata);
    endtask
    task automatic finalReport();
        $display("compared %0d mismatched %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic testRegs();
        rd(`REG_CTRL, `CTRL_RST);
        rd(`REG_HOLD, `HOLD_RST);
        rd(`REG_WAKE1, `WAKE1_RST);
        rd(`REG_WAKE2, `WAKE2_RST);
        rd(`REG_IRQ_MASK, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        chk("ilimDef", 16'(`INPUT_LIMIT_PROGRAM_DEFAULT), 16'(ilimCode));
        chk("termDef", 16'(`TERM_DEFAULT), 16'(termPct));
    endtask
    task automatic testModes();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cd    <= i[1];
            above <= i[0];
            cyc(5);
            chk("chgEn", 16'(i == 1), 16'(chgEn));
            chk("hiZ", 16'(i == 0), 16'(hiZ));
            chk("actBat", 16'(i == 2), 16'(actBat));
            chk("irqN", 16'(i != 1), 16'(irqN));
            chk("pgN", 16'(!i[0]), 16'(pgN));
        end
        @(posedge clk);
        cd   <= 1'b0;
        done <= 1'b1;
        cyc(5);
        chk("doneIrqN", 16'h0001, 16'(irqN));
        @(posedge clk);
        done <= 1'b0;
        wr(`REG_CTRL, 16'h0000);
        cyc(3);
        chk("indOff", 16'h0001, 16'(irqN));
        wr(`REG_CTRL, 16'h0001);
        cyc(3);
        chk("indOn", 16'h0000, 16'(irqN));
        @(posedge clk);
        ovp <= 1'b0;
        cyc(3);
        chk("ovpPgN", 16'h0001, 16'(pgN));
        chk("ovpChg", 16'h0000, 16'(chgEn));
        @(posedge clk);
        ovp <= 1'b1;
        above <= 1'b0;
    endtask
    task automatic testRail();
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk);
            railEn <= i[0];
            cyc(2);
            chk("railSync", 16'(!i[0]), 16'(rail));
            cyc(2);
            chk("rail", 16'(i[0]), 16'(rail));
        end
    endtask
    task automatic testMirror();
        wr(`REG_CTRL, 16'h0003);
        @(posedge clk);
        mr <= 1'b0;
        cyc(5);
        chk("mirrorLow", 16'h0000, 16'(pgN));
        mr <= 1'b1;
        cyc(5);
        chk("mirrorHigh", 16'h0001, 16'(pgN));
        wr(`REG_CTRL, 16'h0001);
        wr(`REG_IRQ_STAT, 16'h001F);
    endtask
    task automatic testFault();
        @(posedge clk);
        fault <= 1'b1;
        n = 0;
        repeat (30) begin
            cyc(1);
            n += (irqOe === 1'b1);
        end
        chk("pulseLen", 16'h0008, 16'(n));
        fault <= 1'b0;
        rd(`REG_IRQ_STAT, 16'h0001);
        chk("irqMasked", 16'h0000, 16'(irq));
        wr(`REG_IRQ_MASK, 16'h001F);
        cyc(2);
        chk("irqOn", 16'h0001, 16'(irq));
        wr(`REG_IRQ_STAT, 16'h0001);
        cyc(2);
        chk("irqClr", 16'h0000, 16'(irq));
        above <= 1'b1;
        cyc(3);
        hot <= 1'b1;
        rd(`REG_IRQ_STAT, 16'h0002);
        hot   <= 1'b0;
        above <= 1'b0;
        wr(`REG_IRQ_STAT, 16'h001F);
    endtask
    task automatic testButton();
        wr(`REG_HOLD, 16'h0003);
        wr(`REG_WAKE1, 16'h0001);
        wr(`REG_WAKE2, 16'h0002);
        wr(`REG_CTRL, 16'h0005);
        cyc(2);
        chk("shipOn", 16'h0001, 16'(ship));
        mr <= 1'b0;
        cyc(28);
        mr <= 1'b1;
        cyc(5);
        chk("shortRst", 16'h0001, 16'(rstN));
        chk("shipOff", 16'h0000, 16'(ship));
        rd(`REG_IRQ_STAT, 16'h000C);
        wr(`REG_IRQ_STAT, 16'h001F);
        mr <= 1'b0;
        n = 0;
        while (rstOe !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk("holdLong", 16'h0001, 16'(n >= 30 && n < 200));
        chk("resetN", 16'h0000, 16'(rstN));
        mr <= 1'b1;
        n = 0;
        while (rstOe === 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
        chk("relLen", 16'h0001, 16'(n >= 3980 && n <= 4010));
        rd(`REG_IRQ_STAT, 16'h001C);
    endtask
    task automatic testLimits();
        ilimGnd <= 1'b0;
        ilimPin <= 8'h20;
        termGnd <= 1'b0;
        termPin <= 5'h0F;
        cyc(3);
        chk("ilimPin", 16'h0020, 16'(ilimCode));
        chk("prePin", 16'h000F, 16'(prePct));
        wr(`REG_INPUT_LIMIT_PROGRAM, 16'h8012);
        wr(`REG_TERM, 16'h8019);
        cyc(2);
        chk("ilimOvr", 16'h0012, 16'(ilimCode));
        chk("termMax", 16'(`TERM_MAX), 16'(termPct));
        wr(`REG_TERM, 16'h8002);
        cyc(2);
        chk("preMin", 16'(`TERM_MIN), 16'(prePct));
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        testRegs();
        testModes();
        testRail();
        testMirror();
        testFault();
        testButton();
        testLimits();
        finalReport();
    end
    initial begin
        #300000;
        failCount++;
        finalReport();
    end
endmodule
